// ==== rtl/ilm_err_counter.sv ====
`timescale 1ns/10ps
`default_nettype none
module ilm_err_counter
  import ilm_pkg::*;
(
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst,
  // Source select and events
  input wire logic [1:0] i_err_sel,
  input wire logic i_logic_err,
  input wire logic i_zero_err,
  input wire logic i_cv_err,
  input wire logic i_transfer,
  // Latched result
  output logic [15:0] o_result
);

  typedef struct packed {
    logic [15:0] count;
    logic [15:0] result;
  } ilm_cnt_s;

  ilm_cnt_s st;
  ilm_cnt_s next_st;
  logic hit;

  // Pick the counted event, then count or transfer
  always_comb begin
    next_st = st;
    case (ilm_src_e'(i_err_sel))
      ILM_SRC_LOGIC: hit = i_logic_err;
      ILM_SRC_ZERO: hit = i_zero_err;
      ILM_SRC_CV: hit = i_cv_err;
      default: hit = i_cv_err | i_zero_err;
    endcase
    if (i_transfer) begin
      next_st.result = st.count;
      // Event in the transfer cycle starts the new count, not lost
      next_st.count = {15'h0000, hit};
    end else if (hit && st.count != COUNT_MAX) begin
      next_st.count = st.count + 16'h0001; // Saturates, no wrap
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign o_result = st.result;

  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (i_rst);

  property p_cnt_xfer;
    i_transfer |=> (o_result == $past(st.count)) && (st.count <= 16'h0001);
  endproperty
  a_cnt_xfer: assert property (p_cnt_xfer)
    else $error("transfer did not latch and clear count");

  property p_cnt_src;
    !i_transfer && i_err_sel == 2'b00 && i_logic_err && !i_cv_err
      && st.count < COUNT_MAX |=> st.count == $past(st.count) + 16'h0001;
  endproperty
  a_cnt_src: assert property (p_cnt_src)
    else $error("logic error not counted");

  property p_cnt_ignore;
    !i_transfer && i_err_sel == 2'b01 && !i_zero_err
      |=> st.count == $past(st.count);
  endproperty
  a_cnt_ignore: assert property (p_cnt_ignore)
    else $error("count moved without selected event");

endmodule
`default_nettype wire

// ==== rtl/ilm_maint_regs.sv ====
`timescale 1ns/10ps
`default_nettype none
module ilm_maint_regs
  import ilm_pkg::*;
(
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst,
  // Host control port
  input wire logic [7:0] i_addr,
  input wire logic i_wr_en,
  input wire logic i_rd_en,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rdata,
  // Line side per channel
  input wire ilm_line_in_s [NUM_CH-1:0] i_line,
  output ilm_line_out_s [NUM_CH-1:0] o_line,
  // Count results per channel, high and low bytes
  output logic [NUM_CH-1:0][15:0] o_count_result
);

  typedef struct packed {
    logic [7:0] rdata;
    ilm_regs_s [NUM_CH-1:0] regs;
    logic [NUM_CH-1:0][2:0] tx_pos;
    logic [NUM_CH-1:0][7:0] rx_hist;
    ilm_line_out_s [NUM_CH-1:0] out;
    logic [NUM_CH-1:0] xfer;
  } ilm_state_s;

  ilm_state_s st;
  ilm_state_s next_st;

  // Mask of the low code bits in use for a length code
  function automatic logic [7:0] len_mask(input logic [1:0] sel);
    case (sel)
      2'b00: len_mask = 8'h1f;
      2'b01: len_mask = 8'h3f;
      2'b10: len_mask = 8'h7f;
      default: len_mask = 8'hff;
    endcase
  endfunction

  // Channel decode: address bit 5 picks the channel copy
  logic wr_ch;
  logic [7:0] offs;
  assign wr_ch = i_addr[CH_SEL_BIT];
  assign offs = i_addr & ~CH_STRIDE;

  always_comb begin
    logic [7:0] w;
    logic [1:0] sel;
    logic [2:0] top;
    logic [7:0] old_ctrl;
    logic [7:0] new_ctrl;
    logic [2:0] pos;
    w = 8'h00;
    sel = 2'b00;
    top = 3'b000;
    old_ctrl = 8'h00;
    new_ctrl = 8'h00;
    pos = 3'b000;
    next_st = st;

    // Register read, answered one cycle later; unmapped reads zero
    if (i_rd_en) begin
      if (offs == ADDR_CODE_LEN) begin
        next_st.rdata = st.regs[wr_ch].lens;
      end else if (offs == ADDR_TX_CODE) begin
        next_st.rdata = st.regs[wr_ch].tx_code;
      end else if (offs == ADDR_ACT_CODE) begin
        next_st.rdata = st.regs[wr_ch].act_code;
      end else if (offs == ADDR_DEACT_CODE) begin
        next_st.rdata = st.regs[wr_ch].deact_code;
      end else if (offs == ADDR_ERR_CTRL) begin
        next_st.rdata = st.regs[wr_ch].ctrl;
      end else begin
        next_st.rdata = 8'h00;
      end
    end

    // Register write; reserved bits are dropped so they read zero
    if (i_wr_en) begin
      w = i_wdata;
      if (offs == ADDR_CODE_LEN) begin
        next_st.regs[wr_ch].lens = w & LEN_WR_MASK;
      end else if (offs == ADDR_TX_CODE) begin
        next_st.regs[wr_ch].tx_code = w;
      end else if (offs == ADDR_ACT_CODE) begin
        next_st.regs[wr_ch].act_code = w;
      end else if (offs == ADDR_DEACT_CODE) begin
        next_st.regs[wr_ch].deact_code = w;
      end else if (offs == ADDR_ERR_CTRL) begin
        next_st.regs[wr_ch].ctrl = w & CTRL_WR_MASK;
      end
    end

    for (int c = 0; c < NUM_CH; c++) begin
      old_ctrl = st.regs[c].ctrl;
      new_ctrl = next_st.regs[c].ctrl;
      // Single shots fire on a written 0 to 1 change only
      next_st.out[c].violation_insert =
        new_ctrl[VIOL_INS_BIT] & ~old_ctrl[VIOL_INS_BIT];
      next_st.out[c].logic_error_insert =
        new_ctrl[LOGIC_LOGIC_ERROR_INSERT_BIT] & ~old_ctrl[LOGIC_LOGIC_ERROR_INSERT_BIT];
      // Auto mode also transfers on each report tick
      next_st.xfer[c] =
        (new_ctrl[XFER_BIT] & ~old_ctrl[XFER_BIT])
        | (old_ctrl[REPORT_MODE_BIT] & i_line[c].report_tick);
      next_st.out[c].zero_run_definition = old_ctrl[ZERO_DEF_BIT];

      // Transmit repeater, code sent most significant used bit first
      sel = st.regs[c].lens[TX_LEN_LSB +: 2];
      top = 3'(4 + sel);
      if (i_line[c].tx_bit_en) begin
        if (i_line[c].tx_pattern_sel == TX_PATTERN_SEL_INBAND) begin
          // Length cut below the saved position restarts the code, index never wraps
          pos = (st.tx_pos[c] > top) ? 3'b000 : st.tx_pos[c];
          next_st.out[c].tx_data = st.regs[c].tx_code[top - pos];
          next_st.tx_pos[c] = (pos >= top) ? 3'b000 : pos + 3'b001;
        end else begin
          next_st.out[c].tx_data = i_line[c].tx_data;
          next_st.tx_pos[c] = 3'b000;
        end
      end

      // Receive matcher over the newest bits, upper code bits masked
      if (i_line[c].rx_bit_en) begin
        next_st.rx_hist[c] = {st.rx_hist[c][6:0], i_line[c].rx_data};
      end
      next_st.out[c].act_detect =
        ((st.rx_hist[c] ^ st.regs[c].act_code)
         & len_mask(st.regs[c].lens[ACT_LEN_LSB +: 2])) == 8'h00;
      next_st.out[c].deact_detect =
        ((st.rx_hist[c] ^ st.regs[c].deact_code)
         & len_mask(st.regs[c].lens[DEACT_LEN_LSB +: 2])) == 8'h00;
    end
  end

  // State register; history reset to ones so no false early match
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      st <= '0;
      for (int c = 0; c < NUM_CH; c++) begin
        st.regs[c].lens <= RST_CODE_LEN;
        st.regs[c].tx_code <= RST_TX_CODE;
        st.regs[c].act_code <= RST_ACT_CODE;
        st.regs[c].deact_code <= RST_DEACT_CODE;
        st.regs[c].ctrl <= RST_ERR_CTRL;
        st.rx_hist[c] <= 8'hff;
      end
    end else begin
      st <= next_st;
    end
  end

  // One error counter per channel
  generate
    for (genvar g = 0; g < NUM_CH; g++) begin : g_cnt
      ilm_err_counter u_cnt (
        .i_mclk(i_mclk),
        .i_rst(i_rst),
        .i_err_sel(st.regs[g].ctrl[ERR_SEL_LSB +: 2]),
        .i_logic_err(i_line[g].logic_err),
        .i_zero_err(i_line[g].zero_err),
        .i_cv_err(i_line[g].cv_err),
        .i_transfer(st.xfer[g]),
        .o_result(o_count_result[g])
      );
    end
  endgenerate

  assign o_rdata = st.rdata;
  assign o_line = st.out;

  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (i_rst);

  sequence s_viol_set;
    i_wr_en && offs == ADDR_ERR_CTRL && !wr_ch && i_wdata[VIOL_INS_BIT]
      && !st.regs[0].ctrl[VIOL_INS_BIT];
  endsequence

  sequence s_one_pulse;
    o_line[0].violation_insert ##1 !o_line[0].violation_insert [*3];
  endsequence

  property p_viol_once;
    s_viol_set |=> s_one_pulse;
  endproperty
  a_viol_once: assert property (p_viol_once)
    else $error("violation insert not a single pulse");

  property p_viol_hold;
    st.regs[0].ctrl[VIOL_INS_BIT] && $past(st.regs[0].ctrl[VIOL_INS_BIT])
      |-> !o_line[0].violation_insert;
  endproperty
  a_viol_hold: assert property (p_viol_hold)
    else $error("held insert bit caused a violation");

  property p_logic_err;
    $rose(st.regs[1].ctrl[LOGIC_LOGIC_ERROR_INSERT_BIT])
      |-> o_line[1].logic_error_insert ##1 !o_line[1].logic_error_insert;
  endproperty
  a_logic_err: assert property (p_logic_err)
    else $error("logic error insert not one pulse");

  property p_xfer_fire;
    $rose(st.regs[0].ctrl[XFER_BIT]) |-> st.xfer[0];
  endproperty
  a_xfer_fire: assert property (p_xfer_fire)
    else $error("transfer not requested on rising bit");

  property p_zero_def;
    $changed(st.regs[0].ctrl[ZERO_DEF_BIT])
      |=> o_line[0].zero_run_definition
        == $past(st.regs[0].ctrl[ZERO_DEF_BIT]);
  endproperty
  a_zero_def: assert property (p_zero_def)
    else $error("zero run definition output lags");

  property p_tx_pass;
    i_line[0].tx_bit_en && i_line[0].tx_pattern_sel != TX_PATTERN_SEL_INBAND
      |=> o_line[0].tx_data == $past(i_line[0].tx_data);
  endproperty
  a_tx_pass: assert property (p_tx_pass)
    else $error("normal data not passed through");

  property p_tx_pos;
    $past(i_line[0].tx_bit_en)
      |-> st.tx_pos[0] <= 3'(4 + $past(st.regs[0].lens[TX_LEN_LSB +: 2]));
  endproperty
  a_tx_pos: assert property (p_tx_pos)
    else $error("transmit position beyond code length");

  property p_reserved;
    st.regs[0].lens[7:6] == 2'b00 && st.regs[1].ctrl[7] == 1'b0;
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("reserved bit stored");

  property p_read_ch2;
    i_rd_en && i_addr == (ADDR_TX_CODE | CH_STRIDE)
      |=> o_rdata == $past(st.regs[1].tx_code);
  endproperty
  a_read_ch2: assert property (p_read_ch2)
    else $error("channel two read wrong");

endmodule
`default_nettype wire

// ==== rtl/ilm_pkg.sv ====
package ilm_pkg;

  // Per-channel register offsets; channel two sits one stride higher
  localparam logic [7:0] ADDR_CODE_LEN = 8'h0e;
  localparam logic [7:0] ADDR_TX_CODE = 8'h0f;
  localparam logic [7:0] ADDR_ACT_CODE = 8'h10;
  localparam logic [7:0] ADDR_DEACT_CODE = 8'h11;
  localparam logic [7:0] ADDR_ERR_CTRL = 8'h12;
  localparam logic [7:0] CH_STRIDE = 8'h20;
  localparam int CH_SEL_BIT = 5;
  localparam int NUM_CH = 2;

  // Length register fields
  localparam int TX_LEN_LSB = 4;
  localparam int ACT_LEN_LSB = 2;
  localparam int DEACT_LEN_LSB = 0;
  localparam logic [7:0] LEN_WR_MASK = 8'h3f;

  // Error insert and count control fields
  localparam int VIOL_INS_BIT = 6;
  localparam int LOGIC_LOGIC_ERROR_INSERT_BIT = 5;
  localparam int ZERO_DEF_BIT = 4;
  localparam int ERR_SEL_LSB = 2;
  localparam int REPORT_MODE_BIT = 1;
  localparam int XFER_BIT = 0;
  localparam logic [7:0] CTRL_WR_MASK = 8'h7f;

  // Values after reset, and the count saturation limit
  localparam logic [7:0] RST_CODE_LEN = 8'h01;
  localparam logic [7:0] RST_TX_CODE = 8'h01;
  localparam logic [7:0] RST_ACT_CODE = 8'h01;
  localparam logic [7:0] RST_DEACT_CODE = 8'h09;
  localparam logic [7:0] RST_ERR_CTRL = 8'h00;
  localparam logic [15:0] COUNT_MAX = 16'hffff;

  // Pattern select code that sends the inband code
  localparam logic [1:0] TX_PATTERN_SEL_INBAND = 2'b11;

  typedef enum logic [1:0] {
    ILM_SRC_LOGIC = 2'b00,
    ILM_SRC_ZERO = 2'b01,
    ILM_SRC_CV = 2'b10,
    ILM_SRC_CV_ZERO = 2'b11
  } ilm_src_e;

  typedef struct packed {
    logic [7:0] lens;
    logic [7:0] tx_code;
    logic [7:0] act_code;
    logic [7:0] deact_code;
    logic [7:0] ctrl;
  } ilm_regs_s;

  // Line side inputs of one channel
  typedef struct packed {
    logic tx_data;
    logic tx_bit_en;
    logic rx_data;
    logic rx_bit_en;
    logic [1:0] tx_pattern_sel;
    logic logic_err;
    logic zero_err;
    logic cv_err;
    logic report_tick;
  } ilm_line_in_s;

  // Line side outputs of one channel
  typedef struct packed {
    logic tx_data;
    logic violation_insert;
    logic logic_error_insert;
    logic zero_run_definition;
    logic act_detect;
    logic deact_detect;
  } ilm_line_out_s;

endpackage

// ==== sim/ilm_host_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module ilm_host_model
  import ilm_pkg::*;
(
  // Clock
  input wire logic i_mclk,
  // Register port
  output logic [7:0] o_addr,
  output logic o_wr_en,
  output logic o_rd_en,
  output logic [7:0] o_wdata,
  input wire logic [7:0] i_rdata
);
  // Idle port at time zero
  initial begin
    o_addr = 8'h00;
    o_wr_en = 1'b0;
    o_rd_en = 1'b0;
    o_wdata = 8'h00;
  end

  // Released lines show inverted values, never stale ones
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge i_mclk);
    o_addr = a;
    o_wdata = d;
    o_wr_en = 1'b1;
    @(negedge i_mclk);
    o_wr_en = 1'b0;
    o_addr = ~a;
    o_wdata = ~d;
  endtask

  // Data sampled an extra cycle late; it stands until next read
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge i_mclk);
    o_addr = a;
    o_rd_en = 1'b1;
    @(negedge i_mclk);
    o_rd_en = 1'b0;
    o_addr = ~a;
    @(negedge i_mclk);
    d = i_rdata;
  endtask

  // Transfer bit set, then cleared so the next rise can happen
  task automatic xfer(input logic [7:0] a, input logic [7:0] c);
    wr(a, c | 8'h01);
    wr(a, c & 8'hfe);
  endtask
endmodule
`default_nettype wire

// ==== sim/tb.sv ====
`timescale 1ns/10ps
`default_nettype none
module tb
  import ilm_pkg::*;
;
  logic i_mclk;
  logic i_rst;
  logic [7:0] addr;
  logic wr_en;
  logic rd_en;
  logic [7:0] wdata;
  logic [7:0] rdata;
  ilm_line_in_s [NUM_CH-1:0] line_in;
  ilm_line_out_s [NUM_CH-1:0] line_out;
  logic [NUM_CH-1:0][15:0] result;
  int error_cnt = 0;
  int compares = 0;
  int vcnt = 0;
  int lcnt = 0;
  int v1cnt = 0;

  ilm_host_model host (.i_mclk(i_mclk), .o_addr(addr), .o_wr_en(wr_en),
    .o_rd_en(rd_en), .o_wdata(wdata), .i_rdata(rdata));

  ilm_maint_regs DUT (.i_mclk(i_mclk), .i_rst(i_rst), .i_addr(addr),
    .i_wr_en(wr_en), .i_rd_en(rd_en), .i_wdata(wdata), .o_rdata(rdata),
    .i_line(line_in), .o_line(line_out), .o_count_result(result));

  // Clock, 8 ns
  initial begin
    i_mclk = 1'b0;
    forever #4 i_mclk = ~i_mclk;
  end

  // Pulse counters, sampled mid-cycle; a long pulse counts more than once
  always @(negedge i_mclk) begin
    if (line_out[0].violation_insert === 1'b1) vcnt++;
    if (line_out[0].logic_error_insert === 1'b1) lcnt++;
    if (line_out[1].violation_insert === 1'b1) v1cnt++;
  end

  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    compares++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR %0t reg got %h exp %h", $time, g, e);
    end
  endtask

  task automatic chk16(input logic [15:0] g, input logic [15:0] e);
    compares++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR %0t count got %h exp %h", $time, g, e);
    end
  endtask

  task automatic chkb(input logic g, input logic e);
    compares++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR %0t line got %b exp %b", $time, g, e);
    end
  endtask

  // Five registers of one channel against a packed expectation
  task automatic rdall(input logic [7:0] base, input logic [39:0] e);
    logic [7:0] d;
    for (int i = 0; i < 5; i++) begin
      host.rd(base + 8'(i), d);
      chk8(d, e[39-8*i -: 8]);
    end
  endtask

  task automatic t_regs;
    logic [7:0] d;
    rdall(8'h0e, 40'h01_0101_0900);
    rdall(8'h2e, 40'h01_0101_0900);
    for (int i = 0; i < 5; i++) host.wr(8'h0e + 8'(i), 8'hff);
    host.wr(8'h13, 8'hff);
    host.rd(8'h13, d);
    chk8(d, 8'h00);
    rdall(8'h0e, 40'h3f_ffff_ff7f);
    rdall(8'h2e, 40'h01_0101_0900);
    host.wr(8'h0e, 8'h01);
    host.wr(8'h0f, 8'h01);
    host.wr(8'h10, 8'h01);
    host.wr(8'h11, 8'h09);
    host.wr(8'h12, 8'h00);
    $display("t_regs done");
  endtask

  task automatic t_ins;
    int v0;
    int l0;
    logic [7:0] d;
    v0 = vcnt;
    l0 = lcnt;
    host.wr(8'h12, 8'h40);
    host.wr(8'h12, 8'h40);
    host.wr(8'h12, 8'h60);
    host.wr(8'h12, 8'h00);
    host.wr(8'h12, 8'h40);
    // Channel two shots must not leak into channel one
    host.wr(8'h32, 8'he0);
    host.rd(8'h32, d);
    chk8(d, 8'h60);
    host.wr(8'h32, 8'h00);
    repeat (3) @(negedge i_mclk);
    chk16(16'(vcnt - v0), 16'h0002);
    chk16(16'(lcnt - l0), 16'h0001);
    chk16(16'(v1cnt), 16'h0001);
    host.wr(8'h12, 8'h10);
    repeat (2) @(negedge i_mclk);
    chkb(line_out[0].zero_run_definition, 1'b1);
    chkb(line_out[1].zero_run_definition, 1'b0);
    host.wr(8'h12, 8'h00);
    $display("t_ins done");
  endtask

  // Event pulses on channel one, one per two cycles
  task automatic ev(input logic [2:0] k, input int n);
    repeat (n) begin
      @(negedge i_mclk);
      {line_in[0].cv_err, line_in[0].zero_err, line_in[0].logic_err} = k;
      @(negedge i_mclk);
      {line_in[0].cv_err, line_in[0].zero_err, line_in[0].logic_err} = '0;
    end
  endtask

  task automatic tick;
    @(negedge i_mclk);
    line_in[0].report_tick = 1'b1;
    @(negedge i_mclk);
    line_in[0].report_tick = 1'b0;
    repeat (2) @(negedge i_mclk);
  endtask

  task automatic t_cnt;
    logic [15:0] e [4] = '{16'h0003, 16'h0005, 16'h0002, 16'h0007};
    logic [7:0] c;
    for (int s = 0; s < 4; s++) begin
      c = 8'(s << 2);
      host.wr(8'h12, c);
      host.xfer(8'h12, c);
      ev(3'b001, 3);
      ev(3'b010, 5);
      ev(3'b100, 2);
      host.xfer(8'h12, c);
      repeat (2) @(negedge i_mclk);
      chk16(result[0], e[s]);
    end
    host.wr(8'h12, 8'h00);
    ev(3'b001, 4);
    tick;
    chk16(result[0], 16'h0007);
    host.wr(8'h12, 8'h02);
    tick;
    chk16(result[0], 16'h0004);
    chk16(result[1], 16'h0000);
    host.wr(8'h12, 8'h00);
    $display("t_cnt done");
  endtask

  // One transmit bit, output checked the cycle after
  task automatic txb(input logic b, input logic e);
    @(negedge i_mclk);
    line_in[0].tx_data = b;
    line_in[0].tx_bit_en = 1'b1;
    @(negedge i_mclk);
    line_in[0].tx_bit_en = 1'b0;
    chkb(line_out[0].tx_data, e);
  endtask

  task automatic t_tx;
    logic [5:0] code = 6'b10_0101;
    logic [7:0] code8 = 8'he5;
    for (int i = 0; i < 3; i++) txb(i[0], i[0]);
    host.wr(8'h0e, 8'h11);
    host.wr(8'h0f, 8'he5);
    line_in[0].tx_pattern_sel = 2'b11;
    for (int i = 0; i < 12; i++) txb(~code[5-i%6], code[5-i%6]);
    host.wr(8'h0e, 8'h31);
    for (int i = 0; i < 8; i++) txb(~code8[7-i], code8[7-i]);
    line_in[0].tx_pattern_sel = 2'b00;
    host.wr(8'h0e, 8'h01);
    $display("t_tx done");
  endtask

  // Received bits oldest first, then one cycle for the detect lag
  task automatic rxb(input logic [5:0] bits, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      @(negedge i_mclk);
      line_in[0].rx_data = bits[i];
      line_in[0].rx_bit_en = 1'b1;
      @(negedge i_mclk);
      line_in[0].rx_bit_en = 1'b0;
    end
    @(negedge i_mclk);
  endtask

  task automatic t_rx;
    host.wr(8'h10, 8'he1);
    rxb(6'b00_1001, 6);
    chkb(line_out[0].deact_detect, 1'b1);
    chkb(line_out[0].act_detect, 1'b0);
    rxb(6'b00_0001, 5);
    chkb(line_out[0].act_detect, 1'b1);
    chkb(line_out[0].deact_detect, 1'b0);
    chkb(line_out[1].act_detect, 1'b0);
    chkb(line_out[1].deact_detect, 1'b0);
    chkb(line_out[1].tx_data, 1'b0);
    $display("t_rx done");
  endtask

  task automatic end_sim;
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    i_rst = 1'b1;
    line_in = '0;
    repeat (8) @(negedge i_mclk);
    i_rst = 1'b0;
    t_regs;
    t_ins;
    t_cnt;
    t_tx;
    t_rx;
    end_sim;
  end

  // Watchdog, several times the expected run
  initial begin
    repeat (5000) @(posedge i_mclk);
    error_cnt++;
    end_sim;
  end
endmodule
`default_nettype wire
